// >>> rtl/cei_regs.sv
/*
 * Comparator edge interrupt register bank: two control registers with
 * edge flag enables and input selects, a result mirror, sticky flags,
 * a mask and one level interrupt, reached over Avalon-MM.
 * Assumes comparator results arrive asynchronously from the analog core.
 */
// Implementation choices: the placing of the registers and the Avalon-MM register port.
// Functional notes
// - A set fall enable raises the comparator flag on a high-to-low edge.
// - Mirror bit 1 reads the second comparator result.
// - Mirror bit 0 reads the first comparator result.
// - Mirror bits 7 to 2 always read zero.
// - Control fields are zero after any reset; mirror fields read zero only until the comparator results pass the two-stage synchroniser.
`timescale 1ns/1ps
module cei_regs (
    input  wire logic                       mclk,
    input  wire logic                       srst,
    input  wire logic [cei_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [cei_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic [cei_pkg::DATA_W-1:0]      avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       first_comparator_result,
    input  wire logic                       second_comparator_result,
    output logic [2:0]                      plus_input_select_1,
    output logic [2:0]                      minus_input_select_1,
    output logic [2:0]                      plus_input_select_2,
    output logic [2:0]                      minus_input_select_2,
    output logic                            irq
);
    import cei_pkg::*;

    logic [7:0]        ctrl1_r, ctrl1_nxt;
    logic [7:0]        ctrl2_r, ctrl2_nxt;
    logic [1:0]        status_r, status_nxt;
    logic [1:0]        mask_r, mask_nxt;
    logic [1:0]        sync1_r, sync2_r;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic              ack_r, ack_nxt;
    logic [1:0]        flag_set;
    logic [1:0]        res;
    logic              wr_go;
    logic              rd_go;

    // Low byte write under byte enable
    function automatic logic [7:0] wr_byte(input logic [7:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        wr_byte = be[0] ? wd[7:0] : old;
    endfunction

    // Two-stage synchroniser for the analog results
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_r <= RST_SYNC;
            sync2_r <= RST_SYNC;
        end else begin
            sync1_r <= {second_comparator_result, first_comparator_result};
            sync2_r <= sync1_r;
        end
    end
    assign res = sync2_r;

    cei_edge_det u_edge1 (
        .mclk     (mclk),
        .srst     (srst),
        .level_in (res[0]),
        .rise_en  (ctrl1_r[BIT_RISE_EN]),
        .fall_en  (ctrl1_r[BIT_FALL_EN]),
        .flag_set (flag_set[0])
    );
    cei_edge_det u_edge2 (
        .mclk     (mclk),
        .srst     (srst),
        .level_in (res[1]),
        .rise_en  (ctrl2_r[BIT_RISE_EN]),
        .fall_en  (ctrl2_r[BIT_FALL_EN]),
        .flag_set (flag_set[1])
    );

    // One wait cycle per access; answer in the next cycle
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign rd_go = avs_read & ~ack_r;

    // Next state of registers and bus answer
    always_comb begin
        ctrl1_nxt  = ctrl1_r;
        ctrl2_nxt  = ctrl2_r;
        mask_nxt   = mask_r;
        status_nxt = status_r;
        rdata_nxt  = rdata_r;
        ack_nxt    = (avs_read | avs_write) & ~ack_r;
        if (wr_go) begin
            case (avs_address)
                OFS_CTRL1: ctrl1_nxt = wr_byte(ctrl1_r, avs_writedata,
                                               avs_byteenable);
                OFS_CTRL2: ctrl2_nxt = wr_byte(ctrl2_r, avs_writedata,
                                               avs_byteenable);
                OFS_MASK:  if (avs_byteenable[0]) begin
                    mask_nxt = avs_writedata[1:0];
                end
                default: ;
            endcase
        end
        if (rd_go) begin
            rdata_nxt = RD_ZERO;
            case (avs_address)
                OFS_CTRL1:  rdata_nxt[7:0] = ctrl1_r;
                OFS_CTRL2:  rdata_nxt[7:0] = ctrl2_r;
                OFS_MIRROR: begin
                    rdata_nxt[BIT_MIRROR_FIRST]  = res[0];
                    rdata_nxt[BIT_MIRROR_SECOND] = res[1];
                end
                OFS_STATUS: begin
                    rdata_nxt[1:0] = status_r;
                    status_nxt     = 2'h0; // Clear on read
                end
                OFS_MASK:   rdata_nxt[1:0] = mask_r;
                default:    rdata_nxt = RD_ZERO;
            endcase
        end
        // Set wins over the read clear
        status_nxt = status_nxt | flag_set;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ctrl1_r  <= RST_CTRL;
            ctrl2_r  <= RST_CTRL;
            status_r <= RST_STATUS;
            mask_r   <= RST_MASK;
            rdata_r  <= RD_ZERO;
            ack_r    <= 1'b0;
        end else begin
            ctrl1_r  <= ctrl1_nxt;
            ctrl2_r  <= ctrl2_nxt;
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            rdata_r  <= rdata_nxt;
            ack_r    <= ack_nxt;
        end
    end

    // Outputs
    assign avs_readdata         = rdata_r;
    assign irq                  = |(status_r & mask_r);
    assign plus_input_select_1  = ctrl1_r[POS_PLUS_SEL +: 3];
    assign minus_input_select_1 = ctrl1_r[POS_MINUS_SEL +: 3];
    assign plus_input_select_2  = ctrl2_r[POS_PLUS_SEL +: 3];
    assign minus_input_select_2 = ctrl2_r[POS_MINUS_SEL +: 3];

    // Assertions
    // fall sets flag 1
    a_fall_flag: assert property (@(posedge mclk) disable iff (srst)
        (ctrl1_r[BIT_FALL_EN] && $fell(res[0])) |=> status_r[0])
        else $error("fall edge did not set flag 1");
    a_fall_flag_two: assert property (@(posedge mclk) disable iff (srst)
        (ctrl2_r[BIT_FALL_EN] && $fell(res[1])) |=> status_r[1])
        else $error("fall edge did not set flag 2");
    a_rise_flag_one: assert property (@(posedge mclk) disable iff (srst)
        (ctrl1_r[BIT_RISE_EN] && $rose(res[0])) |=> status_r[0])
        else $error("rise edge did not set flag 1");
    a_rise_flag: assert property (@(posedge mclk) disable iff (srst)
        (ctrl2_r[BIT_RISE_EN] && $rose(res[1])) |=> status_r[1])
        else $error("rise edge did not set flag 2");
    a_rise_none: assert property (@(posedge mclk) disable iff (srst)
        (!ctrl1_r[BIT_RISE_EN] && !ctrl1_r[BIT_FALL_EN] && !status_r[0])
        |=> !status_r[0])
        else $error("flag 1 set while disabled");
    a_rise_none_two: assert property (@(posedge mclk) disable iff (srst)
        (!ctrl2_r[BIT_RISE_EN] && $rose(res[1]) && !status_r[1])
        |=> !status_r[1])
        else $error("rise edge set flag 2 while rise disabled");
    a_fall_none_two: assert property (@(posedge mclk) disable iff (srst)
        (!ctrl2_r[BIT_FALL_EN] && $fell(res[1]) && !status_r[1])
        |=> !status_r[1])
        else $error("fall edge set flag 2 while fall disabled");
    a_mirror_second: assert property (@(posedge mclk) disable iff (srst)
        (rd_go && avs_address == OFS_MIRROR)
        |=> avs_readdata[1] == $past(res[1]))
        else $error("mirror bit 1 wrong");
    a_mirror_first: assert property (@(posedge mclk) disable iff (srst)
        (rd_go && avs_address == OFS_MIRROR)
        |=> avs_readdata[0] == $past(res[0]))
        else $error("mirror bit 0 wrong");
    a_mirror_upper: assert property (@(posedge mclk) disable iff (srst)
        (rd_go && avs_address == OFS_MIRROR) |=> avs_readdata[31:2] == 30'h0)
        else $error("mirror upper bits not zero");
    a_reset_zero: assert property (@(posedge mclk)
        srst |=> (ctrl1_r == 8'h00 && ctrl2_r == 8'h00 && !irq))
        else $error("registers not zero after reset");
    a_reset_readback: assert property (@(posedge mclk)
        srst |=> (status_r == 2'h0 && avs_readdata == RD_ZERO))
        else $error("status or read data not zero after reset");
    a_irq_level: assert property (@(posedge mclk) disable iff (srst)
        (|(flag_set & mask_r) && !wr_go) |=> irq)
        else $error("masked flag did not raise irq");
    // Main scenarios reached
    c_fall: cover property (@(posedge mclk) flag_set[0] && res[0] == 1'b0);
    c_rise: cover property (@(posedge mclk) flag_set[1] && res[1]);
    c_irq:  cover property (@(posedge mclk) $rose(irq));
    c_clear: cover property (@(posedge mclk)
        rd_go && avs_address == OFS_STATUS && status_r != 2'h0);
    c_rearm: cover property (@(posedge mclk) $fell(srst));
endmodule

// >>> rtl/cei_pkg.sv
/*
 * Package for the comparator edge interrupt register bank: register
 * indices, field positions, reset values and bus widths.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package cei_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    // Word offsets (byte address = 4 * index)
    localparam logic [ADDR_W-1:0] OFS_CTRL1   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CTRL2   = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_MIRROR  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_MASK    = 4'h4;
    // Control register fields
    localparam int unsigned BIT_RISE_EN   = 7;
    localparam int unsigned BIT_FALL_EN   = 6;
    localparam int unsigned POS_PLUS_SEL  = 3;
    localparam int unsigned POS_MINUS_SEL = 0;
    // Mirror fields
    localparam int unsigned BIT_MIRROR_FIRST  = 0;
    localparam int unsigned BIT_MIRROR_SECOND = 1;
    // Reset values
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [1:0] RST_STATUS = 2'h0;
    localparam logic [1:0] RST_MASK   = 2'h0;
    localparam logic [1:0] RST_SYNC   = 2'h0;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;
endpackage

// >>> rtl/cei_edge_det.sv
/*
 * Edge detector for one comparator result bit that is already
 * synchronised to mclk. Emits a one-cycle flag pulse on an enabled edge.
 * Assumes the input is glitch free on mclk.
 */
`timescale 1ns/1ps
module cei_edge_det (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic level_in,
    input  wire logic rise_en,
    input  wire logic fall_en,
    output logic      flag_set
);
    import cei_pkg::*;

    logic prev_r;
    logic prev_nxt;

    // Remember the last sampled level
    always_comb begin
        prev_nxt = level_in;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    always_comb begin
        flag_set = (rise_en & level_in & ~prev_r)
                 | (fall_en & ~level_in & prev_r);
    end
endmodule

// >>> dv/cei_regs_tb.sv
/* Self-checking bench for cei_regs: bus access, mirror, edge flags, irq.
   Assumes the map, layouts and single wait state of cei_pkg. */
`timescale 1ns/1ps
module cei_regs_tb;
    import cei_pkg::*;
    logic              mclk, srst, avs_read, avs_write, res1, res2, irq;
    logic              avs_waitrequest;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, rv, wd;
    logic [3:0]        avs_byteenable;
    logic [2:0]        ps1, ms1, ps2, ms2;
    logic [7:0]        ctl [2];
    logic [1:0]        msk, fl;
    int                failures, tests_run, c, m;
    cei_regs cei_regs_i (.mclk(mclk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .first_comparator_result(res1), .second_comparator_result(res2),
        .plus_input_select_1(ps1), .minus_input_select_1(ms1),
        .plus_input_select_2(ps2), .minus_input_select_2(ms2), .irq(irq));
    // Free running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rv = avs_readdata;
        if (n >= 20) failures++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // Drive one comparator result and let it settle through the sync
    task automatic drive(input int ci, input logic v);
        @(posedge mclk);
        if (ci == 0) res1 <= v;
        else res2 <= v;
        repeat (6) @(posedge mclk);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100us;
        failures++;
        end_of_test();
    end
    // Main sequence
    initial begin
        {srst, avs_read, avs_write, res1, res2} = 5'b10000;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        failures = 0;
        tests_run = 0;
        ctl = '{8'h00, 8'h00};
        void'($urandom(70064));
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        // Reset values, unmapped index included
        for (int a = 0; a < 6; a++) begin
            bus(1'b0, (a == 5) ? 4'hF : 4'(a), 32'h0);
            chk(rv, RD_ZERO);
        end
        chk({18'h0, ps1, ms1, ps2, ms2, irq, avs_waitrequest}, 32'h0);
        $display("test reset done");
        // Control read back; byteenable off and unmapped writes ignored
        for (int k = 0; k < 8; k++) begin
            c = k % 2;
            wd = 32'($urandom);
            avs_byteenable <= (k == 7) ? 4'h0 : 4'hF;
            bus(1'b1, 4'(c), wd);
            if (k != 7) ctl[c] = wd[7:0];
            avs_byteenable <= 4'hF;
            bus(1'b1, 4'hF, 32'($urandom));
            bus(1'b0, 4'(c), 32'h0);
            chk(rv, {24'h0, ctl[c]});
            chk({20'h0, ps1, ms1, ps2, ms2}, {8'h0, ctl[0][5:0], ctl[1][5:0]});
        end
        $display("test control done");
        // Every enable combination on both comparators, random mask
        for (int k = 0; k < 8; k++) begin
            c = k % 2;
            m = k / 2;
            ctl[c] = {2'(m), 6'($urandom)};
            msk = 2'($urandom);
            bus(1'b1, 4'(c), {24'h0, ctl[c]});
            bus(1'b1, OFS_MASK, {30'h0, msk});
            bus(1'b0, OFS_STATUS, 32'h0);
            drive(c, 1'b1);
            bus(1'b0, OFS_MIRROR, 32'h0);
            chk(rv, {30'h0, res2, res1});
            fl = 2'(m / 2) << c;
            chk(irq, |(fl & msk));
            bus(1'b0, OFS_STATUS, 32'h0);
            chk(rv, {30'h0, fl});
            bus(1'b0, OFS_STATUS, 32'h0);
            chk({rv[30:0], irq}, 32'h0);
            drive(c, 1'b0);
            bus(1'b0, OFS_STATUS, 32'h0);
            chk(rv, {30'h0, 2'(m % 2) << c});
        end
        $display("test edges done");
        // Second reset mid-run
        bus(1'b1, OFS_CTRL1, 32'h0000_00FF);
        drive(1, 1'b1);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        bus(1'b0, OFS_CTRL1, 32'h0);
        chk(rv, RD_ZERO);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk({rv[30:0], irq}, 32'h0);
        $display("test second reset done");
        end_of_test();
    end
endmodule
